// ===== verilog/node_switch_config_regs.v
// node configuration register bank of the system packet switch
`include "node_cfg_defs.vh"

module node_switch_config_regs #(
  parameter [7:0] CHIP_ID          = 8'h5A,  // arbitrary value
  parameter [7:0] SWITCH_REVISION  = 8'h01,  // arbitrary value
  parameter [7:0] SWITCH_VERSION   = 8'h02,  // arbitrary value
  parameter [7:0] LINK_COUNT       = 8'h08,
  parameter [7:0] CORE_COUNT       = 8'h01,
  parameter [7:0] LINKS_PER_CORE   = 8'h04,
  parameter       LINK_REGS        = 8,
  parameter       PLINK_REGS       = 4
) (
  input  wire        mclk,
  input  wire        rst_n,
  input  wire        boot_select_pin_0,
  input  wire        boot_select_pin_1,
  input  wire        cfg_req,
  input  wire        cfg_write,
  input  wire [7:0]  cfg_addr,
  input  wire [31:0] cfg_wdata,
  output reg         cfg_ack,
  output reg         cfg_err,
  output reg  [31:0] cfg_rdata,
  input  wire        pkt_valid,
  input  wire [15:0] pkt_dest,
  output reg         route_valid,
  output reg         route_local,
  output reg  [3:0]  route_direction,
  input  wire        debug_from_pin,
  input  wire        debug_from_tile,
  output wire        header_mode_1byte,
  output wire [15:0] node_id,
  output wire [2:0]  pll_output_divider,
  output wire [12:0] pll_feedback_mult,
  output wire [6:0]  pll_input_divider,
  output reg         tile_reset,
  output wire [15:0] switch_clk_div,
  output wire [15:0] ref_clk_div,
  output wire        debug_pulldown_en,
  output wire        debug_dcall_en
);

  // ----------------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------------
  reg  [31:0] control_r;
  reg  [15:0] node_id_r;
  reg  [31:0] pll_r;
  reg  [15:0] sw_clk_div_r;
  reg  [15:0] ref_clk_div_r;
  reg  [31:0] dir_low_r;
  reg  [31:0] dir_high_r;
  reg  [1:0]  debug_pin_r;
  reg  [1:0]  debug_origin_r;
  reg  [31:0] link_r   [0:LINK_REGS-1];
  reg  [31:0] plink_r  [0:PLINK_REGS-1];
  reg  [31:0] setup_r  [0:LINK_REGS-1];
  reg  [31:0] static_r [0:LINK_REGS-1];
  reg  [31:0] rdata_nxt;
  reg         known_nxt;

  wire [1:0]  boot_mode;
  wire        boot_mode_load;
  wire        route_local_nxt;
  wire [3:0]  route_direction_nxt;
  wire        wr_req;
  wire        global_lock;
  wire        wr_ok;
  wire        pll_wr;
  wire [2:0]  link_idx;
  wire [1:0]  plink_idx;

  integer     k;

  // ----------------------------------------------------------------------------
  // address decode helpers
  // ----------------------------------------------------------------------------
  // true when addr falls in an array window of n words starting at base
  function in_window;
    input [7:0] addr;
    input [7:0] base;
    input integer n;
    begin
      in_window = (addr >= base) && ({24'h0, addr} < ({24'h0, base} + n));
    end
  endfunction

  // reset value of the PLL word for a captured boot mode
  function [31:0] pll_reset_value;
    input [1:0] mode;
    begin
      case (mode)
        2'h0:    pll_reset_value = `RST_PLL_BOOT_SELECT_PIN_0;
        2'h1:    pll_reset_value = `RST_PLL_BOOT_SELECT_PIN_1;
        2'h2:    pll_reset_value = `RST_PLL_MODE2;
        default: pll_reset_value = `RST_PLL_MODE3;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------------
  // sub-blocks
  // ----------------------------------------------------------------------------
  boot_mode_sampler u_boot_mode (
    .mclk              (mclk),
    .rst_n             (rst_n),
    .boot_select_pin_0 (boot_select_pin_0),
    .boot_select_pin_1 (boot_select_pin_1),
    .boot_mode_r       (boot_mode),
    .boot_mode_load_r  (boot_mode_load)
  );

  route_direction_select #(
    .ID_W (16)
  ) u_route (
    .node_id    (node_id_r),
    .dest_id    (pkt_dest),
    .directions ({dir_high_r, dir_low_r}),
    .is_local   (route_local_nxt),
    .direction  (route_direction_nxt)
  );

  // ----------------------------------------------------------------------------
  // write qualification
  // ----------------------------------------------------------------------------
  assign wr_req      = cfg_req && cfg_write;
  assign global_lock = control_r[`CTL_GLOBAL_LOCK];
  assign wr_ok       = wr_req && !global_lock;
  // the PLL lock refuses only this word; the rest stays writable
  assign pll_wr      = wr_ok && (cfg_addr == `OFF_PLL) &&
                       !control_r[`CTL_PLL_LOCK];
  assign link_idx    = cfg_addr[2:0];
  assign plink_idx   = cfg_addr[1:0];

  // ----------------------------------------------------------------------------
  // scalar registers
  // ----------------------------------------------------------------------------
  // the global lock, once set, also guards its own word, so only reset clears it
  always @(posedge mclk) begin
    if (!rst_n) begin
      control_r     <= `RST_CONTROL;
      node_id_r     <= `RST_NODE_ID;
      sw_clk_div_r  <= `RST_SW_CLK_DIV;
      ref_clk_div_r <= `RST_REF_CLK_DIV;
      dir_low_r     <= `RST_DIRECTIONS;
      dir_high_r    <= `RST_DIRECTIONS;
      debug_pin_r   <= 2'h0;
    end else if (wr_ok) begin
      case (cfg_addr)
        `OFF_CONTROL: begin
          control_r <= 32'h0;
          control_r[`CTL_GLOBAL_LOCK] <= cfg_wdata[`CTL_GLOBAL_LOCK];
          control_r[`CTL_PLL_LOCK]    <= cfg_wdata[`CTL_PLL_LOCK];
          control_r[`CTL_HEADER_MODE] <= cfg_wdata[`CTL_HEADER_MODE];
        end
        `OFF_NODE_ID:     node_id_r     <= cfg_wdata[15:0];
        `OFF_SW_CLK_DIV:  sw_clk_div_r  <= cfg_wdata[15:0];
        `OFF_REF_CLK_DIV: ref_clk_div_r <= cfg_wdata[15:0];
        `OFF_DIR_LOW:     dir_low_r     <= cfg_wdata;
        `OFF_DIR_HIGH:    dir_high_r    <= cfg_wdata;
        `OFF_DEBUG_PIN:   debug_pin_r   <= cfg_wdata[1:0];
        default:          debug_pin_r   <= debug_pin_r;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // PLL settings word and tile reset
  // ----------------------------------------------------------------------------
  // boot-mode load waits for the synchroniser, so a write cannot race it in
  // practice; a write in the same cycle still wins as the newer value
  always @(posedge mclk) begin
    if (!rst_n) begin
      pll_r      <= `RST_PLL_BOOT_SELECT_PIN_0;
      tile_reset <= 1'b0;
    end else begin
      tile_reset <= pll_wr;
      if (pll_wr) begin
        pll_r <= cfg_wdata & `PLL_WRITE_MASK;
      end else if (boot_mode_load) begin
        pll_r <= pll_reset_value(boot_mode);
      end
    end
  end

  // ----------------------------------------------------------------------------
  // debug source: hardware records the latest event, software cannot write
  // ----------------------------------------------------------------------------
  always @(posedge mclk) begin
    if (!rst_n) begin
      debug_origin_r <= 2'h0;
    end else if (debug_from_pin || debug_from_tile) begin
      debug_origin_r <= {debug_from_pin, debug_from_tile};
    end
  end

  // ----------------------------------------------------------------------------
  // link register arrays, only their writable fields are stored
  // ----------------------------------------------------------------------------
  always @(posedge mclk) begin
    if (!rst_n) begin
      for (k = 0; k < LINK_REGS; k = k + 1) begin
        link_r[k]   <= 32'h0;
        setup_r[k]  <= 32'h0;
        static_r[k] <= 32'h0;
      end
      for (k = 0; k < PLINK_REGS; k = k + 1) begin
        plink_r[k] <= 32'h0;
      end
    end else if (wr_ok) begin
      if (in_window(cfg_addr, `OFF_LINK_BASE, LINK_REGS)) begin
        link_r[link_idx] <= cfg_wdata & `LINK_WRITE_MASK;
      end
      if (in_window(cfg_addr, `OFF_PLINK_BASE, PLINK_REGS)) begin
        plink_r[plink_idx] <= cfg_wdata & `PLINK_WRITE_MASK;
      end
      if (in_window(cfg_addr, `OFF_LINK_SETUP, LINK_REGS)) begin
        setup_r[link_idx] <= cfg_wdata;
      end
      if (in_window(cfg_addr, `OFF_STATIC_LINK, LINK_REGS)) begin
        static_r[link_idx] <= cfg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------------
  always @* begin
    rdata_nxt = 32'h0;
    known_nxt = 1'b1;
    case (cfg_addr)
      `OFF_IDENTITY:     rdata_nxt = {CHIP_ID, 6'h0, boot_mode,
                                      SWITCH_REVISION, SWITCH_VERSION};
      `OFF_DESCRIPTION:  rdata_nxt = {8'h0, LINK_COUNT, CORE_COUNT,
                                      LINKS_PER_CORE};
      `OFF_CONTROL:      rdata_nxt = control_r;
      `OFF_NODE_ID:      rdata_nxt = {16'h0, node_id_r};
      `OFF_PLL:          rdata_nxt = pll_r;
      `OFF_SW_CLK_DIV:   rdata_nxt = {16'h0, sw_clk_div_r};
      `OFF_REF_CLK_DIV:  rdata_nxt = {16'h0, ref_clk_div_r};
      `OFF_DIR_LOW:      rdata_nxt = dir_low_r;
      `OFF_DIR_HIGH:     rdata_nxt = dir_high_r;
      `OFF_DEBUG_PIN:    rdata_nxt = {30'h0, debug_pin_r};
      `OFF_DEBUG_ORIGIN: rdata_nxt = {27'h0, debug_origin_r[1], 3'h0,
                                      debug_origin_r[0]};
      default: begin
        if (in_window(cfg_addr, `OFF_LINK_BASE, LINK_REGS)) begin
          rdata_nxt = link_r[link_idx];
        end else if (in_window(cfg_addr, `OFF_PLINK_BASE, PLINK_REGS)) begin
          rdata_nxt = plink_r[plink_idx];
        end else if (in_window(cfg_addr, `OFF_LINK_SETUP, LINK_REGS)) begin
          rdata_nxt = setup_r[link_idx];
        end else if (in_window(cfg_addr, `OFF_STATIC_LINK, LINK_REGS)) begin
          rdata_nxt = static_r[link_idx];
        end else begin
          known_nxt = 1'b0;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------------------
  // transaction answer, one cycle after the request
  // ----------------------------------------------------------------------------
  // refused writes answer with an error so the requester can tell they failed
  always @(posedge mclk) begin
    if (!rst_n) begin
      cfg_ack   <= 1'b0;
      cfg_err   <= 1'b0;
      cfg_rdata <= 32'h0;
    end else begin
      cfg_ack <= cfg_req;
      cfg_err <= cfg_req && (!known_nxt || (cfg_write && (global_lock ||
                 ((cfg_addr == `OFF_PLL) && control_r[`CTL_PLL_LOCK]))));
      if (cfg_req && !cfg_write) begin
        cfg_rdata <= rdata_nxt;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // registered routing decision
  // ----------------------------------------------------------------------------
  always @(posedge mclk) begin
    if (!rst_n) begin
      route_valid     <= 1'b0;
      route_local     <= 1'b0;
      route_direction <= 4'h0;
    end else begin
      route_valid <= pkt_valid;
      if (pkt_valid) begin
        route_local     <= route_local_nxt;
        route_direction <= route_direction_nxt;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // control outputs
  // ----------------------------------------------------------------------------
  // header mode must match on all nodes; this node cannot check that
  assign header_mode_1byte  = control_r[`CTL_HEADER_MODE];
  assign node_id            = node_id_r;
  assign pll_output_divider = pll_r[`PLL_OD_MSB:`PLL_OD_LSB];
  assign pll_feedback_mult  = pll_r[`PLL_F_MSB:`PLL_F_LSB];
  assign pll_input_divider  = pll_r[`PLL_R_MSB:`PLL_R_LSB];
  assign switch_clk_div     = sw_clk_div_r;
  assign ref_clk_div        = ref_clk_div_r;
  assign debug_pulldown_en  = debug_pin_r[0];
  assign debug_dcall_en     = debug_pin_r[1];

endmodule // node_switch_config_regs

// ===== verilog/node_cfg_defs.vh
// constants of the node configuration register bank
//
// Overview of operation
// - Node registers are reached only by configuration read and write transactions sent to this node.
// - While bit 31 of the switch control word is one, every configuration write to this switch is refused.
// - While bit 8 of the switch control word is one, the PLL settings word cannot be updated.
// - Bit 0 of the switch control word set to one selects single-byte packet headers.
// - The switch control word resets to zero and its bits 30:9 and 7:1 are reserved.
// - The node identifier register holds a writable 16-bit ID in bits 15:0, reset zero, upper bits reserved.
// - Routing compares a destination against the node ID from the most significant bit downward.
// - Any accepted write to the PLL settings word resets the tile.
// - PLL settings hold output divider 25:23, feedback multiplier 20:8, input divider 6:0, rest read-only.
// - The PLL field reset values are chosen from the two boot-select pin levels.
// - The identity word shows sampled boot-select pins in 23:16 and a chip identifier in 31:24, all read-only.
// - The identity word shows switch revision in 15:8 and switch version in 7:0, read-only.
// - The description word shows link count 23:16, core count 15:8 and links per processor 7:0.
`ifndef NODE_CFG_DEFS_VH
`define NODE_CFG_DEFS_VH

// ----------------------------------------------------------------------------
// register numbers
// ----------------------------------------------------------------------------
`define OFF_IDENTITY     8'h00
`define OFF_DESCRIPTION  8'h01
`define OFF_CONTROL      8'h04
`define OFF_NODE_ID      8'h05
`define OFF_PLL          8'h06
`define OFF_SW_CLK_DIV   8'h07
`define OFF_REF_CLK_DIV  8'h08
`define OFF_DIR_LOW      8'h0C
`define OFF_DIR_HIGH     8'h0D
`define OFF_DEBUG_PIN    8'h10
`define OFF_DEBUG_ORIGIN 8'h1F
`define OFF_LINK_BASE    8'h20
`define OFF_PLINK_BASE   8'h40
`define OFF_LINK_SETUP   8'h80
`define OFF_STATIC_LINK  8'hA0

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CTL_GLOBAL_LOCK  31
`define CTL_PLL_LOCK     8
`define CTL_HEADER_MODE  0
`define PLL_OD_MSB       25
`define PLL_OD_LSB       23
`define PLL_F_MSB        20
`define PLL_F_LSB        8
`define PLL_R_MSB        6
`define PLL_R_LSB        0
`define PLL_WRITE_MASK   32'h039FFF7F
`define LINK_WRITE_MASK  32'h00000F30
`define PLINK_WRITE_MASK 32'h00000030

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define RST_CONTROL      32'h00000000
`define RST_NODE_ID      16'h0000
`define RST_SW_CLK_DIV   16'h0000
`define RST_REF_CLK_DIV  16'h0003
`define RST_DIRECTIONS   32'h00000000
`define RST_PLL_BOOT_SELECT_PIN_0    32'h00800100
`define RST_PLL_BOOT_SELECT_PIN_1    32'h00800200
`define RST_PLL_MODE2    32'h00800300
`define RST_PLL_MODE3    32'h00800400

`endif

// ===== verilog/boot_mode_sampler.v
// boot-select pin synchroniser and capture at reset release
`include "node_cfg_defs.vh"

module boot_mode_sampler (
  input  wire       mclk,
  input  wire       rst_n,
  input  wire       boot_select_pin_0,
  input  wire       boot_select_pin_1,
  output reg  [1:0] boot_mode_r,
  output reg        boot_mode_load_r
);

  reg [1:0] pin_meta_r;
  reg [1:0] pin_sync_r;
  reg       captured_r;

  // ----------------------------------------------------------------------------
  // two-flop synchroniser, pins are asynchronous to mclk
  // ----------------------------------------------------------------------------
  always @(posedge mclk) begin
    pin_meta_r <= {boot_select_pin_1, boot_select_pin_0};
    pin_sync_r <= pin_meta_r;
  end

  // capture once after reset; later pin changes are ignored until next reset
  always @(posedge mclk) begin
    if (!rst_n) begin
      boot_mode_r      <= 2'h0;
      boot_mode_load_r <= 1'b0;
      captured_r       <= 1'b0;
    end else begin
      boot_mode_load_r <= 1'b0;
      if (!captured_r) begin
        boot_mode_r      <= pin_sync_r;
        boot_mode_load_r <= 1'b1;
        captured_r       <= 1'b1;
      end
    end
  end

endmodule // boot_mode_sampler

// ===== verilog/route_direction_select.v
// most-significant-mismatch direction lookup against the node ID
module route_direction_select #(
  parameter ID_W = 16
) (
  input  wire [ID_W-1:0]   node_id,
  input  wire [ID_W-1:0]   dest_id,
  input  wire [4*ID_W-1:0] directions,
  output reg               is_local,
  output reg  [3:0]        direction
);

  integer   i;
  reg       found;

  // ----------------------------------------------------------------------------
  // scan from msb down; first mismatching bit picks the direction
  // ----------------------------------------------------------------------------
  always @* begin
    found     = 1'b0;
    direction = 4'h0;
    for (i = ID_W - 1; i >= 0; i = i - 1) begin
      if (!found && (node_id[i] != dest_id[i])) begin
        found     = 1'b1;
        direction = directions[4*i +: 4];
      end
    end
    is_local = !found;
  end

endmodule // route_direction_select

// ===== verification/node_switch_config_regs_assertions.sv
// bound checker for the node configuration register bank
module node_switch_config_regs_checker (
  input wire        mclk,
  input wire        rst_n,
  input wire        cfg_req,
  input wire        cfg_write,
  input wire [7:0]  cfg_addr,
  input wire [31:0] cfg_wdata,
  input wire        cfg_ack,
  input wire        cfg_err,
  input wire        pkt_valid,
  input wire [15:0] pkt_dest,
  input wire        route_valid,
  input wire        route_local,
  input wire [3:0]  route_direction,
  input wire        header_mode_1byte,
  input wire [15:0] node_id,
  input wire [2:0]  pll_output_divider,
  input wire [12:0] pll_feedback_mult,
  input wire [6:0]  pll_input_divider,
  input wire        tile_reset,
  input wire [15:0] ref_clk_div
);
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------------------------------------
  // shadow of the lock bits and of the last accepted write
  // ------------------------------------------------------------
  logic        lock_r;
  logic        pll_lock_r;
  logic        acc_r;
  logic [7:0]  addr_r;
  logic [31:0] wdata_r;
  wire         wr_now  = cfg_req && cfg_write;
  wire         acc_nxt = wr_now && !lock_r && !(cfg_addr == 8'h06 && pll_lock_r);

  // locks move only on accepted control writes: a locked bank cannot unlock itself
  always @(posedge mclk) begin
    if (!rst_n) begin
      lock_r     <= 1'b0;
      pll_lock_r <= 1'b0;
      acc_r      <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      if (acc_nxt && cfg_addr == 8'h04) begin
        lock_r     <= cfg_wdata[31];
        pll_lock_r <= cfg_wdata[8];
      end
    end
  end

  // last request fields, only looked at while acc_r is high
  always @(posedge mclk) begin
    addr_r  <= cfg_addr;
    wdata_r <= cfg_wdata;
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  ack_after_req_a: assert property (cfg_req |=> cfg_ack)
    else $error("no ack one cycle after a request");
  ack_needs_req_a: assert property (!cfg_req |=> !cfg_ack && !cfg_err)
    else $error("ack or err without a request");
  global_lock_a: assert property (lock_r && wr_now |=> cfg_err && !tile_reset)
    else $error("write accepted under the global lock");
  pll_lock_a: assert property (wr_now && cfg_addr == 8'h06 && pll_lock_r
    |=> cfg_err && !tile_reset && $stable(pll_feedback_mult))
    else $error("pll word changed under its lock");
  header_mode_a: assert property (acc_r && addr_r == 8'h04 |-> header_mode_1byte == wdata_r[0])
    else $error("header mode does not follow control bit 0");
  reset_value_a: assert property ($rose(rst_n)
    |-> !header_mode_1byte && node_id == 16'h0000 && ref_clk_div == 16'h0003)
    else $error("wrong value after reset");
  node_id_a: assert property (acc_r && addr_r == 8'h05 |-> node_id == wdata_r[15:0])
    else $error("node id not taken from write");
  route_local_a: assert property (pkt_valid && pkt_dest == node_id
    |=> route_valid && route_local && route_direction == 4'h0)
    else $error("own id not routed locally");
  tile_reset_cause_a: assert property (!(wr_now && cfg_addr == 8'h06) |=> !tile_reset)
    else $error("tile reset without a pll write");
  pll_fields_a: assert property (acc_r && addr_r == 8'h06
    |-> tile_reset && pll_input_divider == wdata_r[6:0] && pll_output_divider == wdata_r[25:23])
    else $error("pll write not applied");
  ro_write_a: assert property (wr_now && !lock_r && cfg_addr <= 8'h01 |=> cfg_ack && !cfg_err)
    else $error("write to a read-only word refused");
endmodule // node_switch_config_regs_checker

bind node_switch_config_regs node_switch_config_regs_checker i_chk (
  .mclk, .rst_n, .cfg_req, .cfg_write, .cfg_addr, .cfg_wdata, .cfg_ack, .cfg_err, .pkt_valid, .pkt_dest,
  .route_valid, .route_local, .route_direction, .header_mode_1byte, .node_id, .pll_output_divider,
  .pll_feedback_mult, .pll_input_divider, .tile_reset, .ref_clk_div
);

// ===== verification/cfg_host_model.sv
// configuration requester standing in for a processor tile or debugger
module cfg_host_model (
  input  wire         mclk,
  output logic        cfg_req,
  output logic        cfg_write,
  output logic [7:0]  cfg_addr,
  output logic [31:0] cfg_wdata,
  input  wire         cfg_ack,
  input  wire         cfg_err,
  input  wire  [31:0] cfg_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    cfg_req   = 1'b0;
    cfg_write = 1'b0;
    cfg_addr  = 8'h00;
    cfg_wdata = 32'h00000000;
  end

  // one request pulse; idle cycles first model a slow requester
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input int idle,
                      output logic [31:0] rd, output logic ack, output logic err);
    repeat (idle) @(posedge mclk);
    @(posedge mclk);
    cfg_req   <= 1'b1;
    cfg_write <= w;
    cfg_addr  <= a;
    cfg_wdata <= d;
    @(posedge mclk);
    cfg_req   <= 1'b0;
    cfg_addr  <= ~a; // released address and data lines never keep the last value
    cfg_wdata <= ~d;
    #1;
    rd  = cfg_rdata;
    ack = cfg_ack;
    err = cfg_err;
  endtask
endmodule // cfg_host_model

// ===== verification/node_switch_config_regs_bench.sv
// self-checking testbench of the node configuration register bank
module node_switch_config_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk, rst_n, boot_select_pin_0, boot_select_pin_1, pkt_valid, debug_from_pin, debug_from_tile;
  logic [15:0] pkt_dest;
  wire         cfg_req, cfg_write, cfg_ack, cfg_err, route_valid, route_local, header_mode_1byte, tile_reset;
  wire  [7:0]  cfg_addr;
  wire  [31:0] cfg_wdata, cfg_rdata;
  wire  [3:0]  route_direction;
  wire  [15:0] node_id;
  wire  [2:0]  pll_output_divider;
  wire  [12:0] pll_feedback_mult;
  wire  [6:0]  pll_input_divider;
  wire  [15:0] switch_clk_div;
  wire         debug_pulldown_en, debug_dcall_en;
  int          fails, compares, cyc;

  node_switch_config_regs i_dut (
    .mclk, .rst_n, .boot_select_pin_0, .boot_select_pin_1, .cfg_req, .cfg_write, .cfg_addr, .cfg_wdata,
    .cfg_ack, .cfg_err, .cfg_rdata, .pkt_valid, .pkt_dest, .route_valid, .route_local, .route_direction,
    .debug_from_pin, .debug_from_tile, .header_mode_1byte, .node_id, .pll_output_divider,
    .pll_feedback_mult, .pll_input_divider, .tile_reset, .switch_clk_div, .ref_clk_div(),
    .debug_pulldown_en, .debug_dcall_en
  );
  cfg_host_model i_host (.mclk, .cfg_req, .cfg_write, .cfg_addr, .cfg_wdata, .cfg_ack, .cfg_err, .cfg_rdata);

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ------------------------------------------------------------
  // access and compare tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cfg_wr(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    logic [31:0] rd;
    logic        ack, err;
    i_host.xfer(1'b1, a, d, 0, rd, ack, err);
    chk("write ack", 32'h1, {31'h0, ack});
    chk("write err", e, {31'h0, err});
  endtask
  task automatic cfg_rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] e);
    logic [31:0] rd;
    logic        ack, err;
    i_host.xfer(1'b0, a, 32'h0, 1, rd, ack, err);
    chk("read ack", 32'h1, {31'h0, ack});
    chk("read err", e, {31'h0, err});
    chk("read data", x, rd);
  endtask
  task automatic look(input logic [15:0] dest, input logic loc, input logic [3:0] dir);
    @(posedge mclk);
    pkt_valid <= 1'b1;
    pkt_dest  <= dest;
    @(posedge mclk);
    pkt_valid <= 1'b0;
    pkt_dest  <= ~dest;
    #1;
    chk("route", {26'h1, loc, 1'b0, dir}, {25'h0, route_valid, route_local, 1'b0, route_direction});
  endtask
  // pins change at reset start so they are steady long before release
  task automatic do_reset(input logic p1, input logic p0);
    @(posedge mclk);
    rst_n             <= 1'b0;
    boot_select_pin_0 <= p0;
    boot_select_pin_1 <= p1;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask
  task test_done;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // hang guard: the whole sequence needs well under 1000 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      test_done;
    end
  end

  initial begin
    {rst_n, boot_select_pin_1, boot_select_pin_0, pkt_valid, debug_from_pin, debug_from_tile} = 6'b001000;
    pkt_dest = 16'h0000;
    do_reset(1'b0, 1'b1);
    cfg_rd(8'h00, 32'h5A010102, 0);
    cfg_rd(8'h01, 32'h00080104, 0);
    cfg_rd(8'h04, 32'h00000000, 0);
    cfg_rd(8'h05, 32'h00000000, 0);
    cfg_rd(8'h06, 32'h00800200, 0);
    cfg_wr(8'h04, 32'h7FFFFFFF, 0);
    cfg_rd(8'h04, 32'h00000101, 0);
    chk("header mode", 32'h1, {31'h0, header_mode_1byte});
    cfg_wr(8'h06, 32'h01234567, 1);
    chk("tile reset", 32'h0, {31'h0, tile_reset});
    cfg_rd(8'h06, 32'h00800200, 0);
    cfg_wr(8'h05, 32'hFFFF1234, 0);
    cfg_rd(8'h05, 32'h00001234, 0);
    cfg_wr(8'h04, 32'h00000001, 0);
    cfg_wr(8'h06, 32'hFFFFFFFF, 0);
    chk("tile reset", 32'h1, {31'h0, tile_reset});
    cfg_rd(8'h06, 32'h039FFF7F, 0);
    chk("pll fields", 32'h007FFFFF, {9'h0, pll_output_divider, pll_feedback_mult, pll_input_divider});
    cfg_wr(8'h00, 32'hFFFFFFFF, 0);
    cfg_rd(8'h00, 32'h5A010102, 0);
    cfg_wr(8'h01, 32'h00000000, 0);
    cfg_rd(8'h01, 32'h00080104, 0);
    cfg_rd(8'h02, 32'h00000000, 1);
    cfg_wr(8'h0C, 32'h76543210, 0);
    cfg_wr(8'h0D, 32'hFEDCBA98, 0);
    look(16'h1234, 1'b1, 4'h0);
    look(16'h9234, 1'b0, 4'hF);
    look(16'h1635, 1'b0, 4'hA);
    look(16'h1230, 1'b0, 4'h2);
    // plain words and link arrays keep only their writable bits
    cfg_wr(8'h07, 32'hFFFFABCD, 0);
    cfg_rd(8'h07, 32'h0000ABCD, 0);
    chk("switch clk div", 32'h0000ABCD, {16'h0, switch_clk_div});
    cfg_wr(8'h10, 32'hFFFFFFFF, 0);
    cfg_rd(8'h10, 32'h00000003, 0);
    chk("debug pin", 32'h3, {30'h0, debug_dcall_en, debug_pulldown_en});
    cfg_wr(8'h27, 32'hFFFFFFFF, 0);
    cfg_rd(8'h27, 32'h00000F30, 0);
    cfg_wr(8'h43, 32'hFFFFFFFF, 0);
    cfg_rd(8'h43, 32'h00000030, 0);
    // both debug events in one cycle set both source bits
    @(posedge mclk);
    {debug_from_pin, debug_from_tile} <= 2'b11;
    @(posedge mclk);
    {debug_from_pin, debug_from_tile} <= 2'b00;
    cfg_rd(8'h1F, 32'h00000011, 0);
    cfg_wr(8'h1F, 32'h00000000, 0);
    cfg_rd(8'h1F, 32'h00000011, 0);
    cfg_wr(8'h04, 32'h80000000, 0);
    cfg_wr(8'h05, 32'h00000000, 1);
    cfg_wr(8'h04, 32'h00000000, 1);
    cfg_wr(8'h06, 32'h00000000, 1);
    chk("tile reset", 32'h0, {31'h0, tile_reset});
    cfg_rd(8'h05, 32'h00001234, 0);
    cfg_rd(8'h04, 32'h80000000, 0);
    do_reset(1'b1, 1'b0);
    cfg_rd(8'h00, 32'h5A020102, 0);
    cfg_rd(8'h06, 32'h00800300, 0);
    cfg_rd(8'h04, 32'h00000000, 0);
    do_reset(1'b1, 1'b1);
    cfg_rd(8'h00, 32'h5A030102, 0);
    cfg_rd(8'h06, 32'h00800400, 0);
    test_done;
  end
endmodule // node_switch_config_regs_bench
